// ### logic/mist_top.sv
// interrupt status flags, mask and AHB-Lite register slave
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module mist_top (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    input wire logic SUPPLY_LOW,
    input wire logic SAG_C_EVT,
    input wire logic [2:0] ZC_TIMEOUT_EVT,
    input wire logic [2:0] ZC_RISE_EVT,
    input wire logic HALF_CYCLE_EVT,
    input wire logic WAVE_SAMPLE_EVT,
    input wire logic [35:0] VOLT_MAG,
    input wire logic [35:0] CURR_MAG,
    input wire logic MAG_VALID,
    input wire logic [2:0] ACT_SIGN,
    input wire logic [2:0] REACT_SIGN,
    input wire logic PWR_VALID,
    output logic SW_RESET_PULSE,
    output logic IRQ_N
);
    typedef enum logic [0:0] {SEQ_IDLE, SEQ_AFTER_A} mist_seq_t;

    mist_evt_if ev ();

    logic sup_meta_r;
    logic sup_sync_r;
    logic sup_prev_r;
    logic soft_rst_r;
    logic soft_req;
    logic acc;
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r;
    logic irq_n_r;
    logic [mist_pkg::STATUS_W-1:0] mask_r;
    logic [mist_pkg::MAG_W-1:0] volt_peak_threshold;
    logic [mist_pkg::MAG_W-1:0] curr_peak_threshold;
    logic [3:0] measure_mode_reg;
    logic [3:0] computation_mode_reg;
    logic [mist_pkg::LCYC_W-1:0] half_cycle_count;
    logic [mist_pkg::STATUS_W-1:0] set_vec;
    logic volt_peak_hit;
    logic curr_peak_hit;
    logic seq_err_hit;
    mist_seq_t seq_r;
    mist_seq_t seq_nxt;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // picks one phase magnitude; code 3 falls back to phase A
    function automatic logic [mist_pkg::MAG_W-1:0] pick_mag(
        input logic [35:0] mags,
        input logic [1:0] sel
    );
        logic [mist_pkg::MAG_W-1:0] m;
        m = mags[11:0];
        case (sel)
            2'h1: m = mags[23:12];
            2'h2: m = mags[35:24];
            default: m = mags[11:0];
        endcase
        return m;
    endfunction

    function automatic logic [31:0] rd_mux(
        input logic [7:0] a,
        input logic [mist_pkg::STATUS_W-1:0] st,
        input logic [mist_pkg::STATUS_W-1:0] mk,
        input logic [mist_pkg::MAG_W-1:0] vt,
        input logic [mist_pkg::MAG_W-1:0] it,
        input logic [3:0] mm,
        input logic [3:0] cm,
        input logic [mist_pkg::LCYC_W-1:0] hc
    );
        logic [31:0] d;
        d = 32'h00000000;
        case (a)
            mist_pkg::OFS_STATUS: d = {12'h000, st};
            mist_pkg::OFS_CLEAR_VIEW: d = {12'h000, st};
            mist_pkg::OFS_MASK: d = {12'h000, mk};
            mist_pkg::OFS_VPEAK_THR: d = {20'h00000, vt};
            mist_pkg::OFS_IPEAK_THR: d = {20'h00000, it};
            mist_pkg::OFS_MEASURE_MODE: d = {28'h0000000, mm};
            mist_pkg::OFS_COMP_MODE: d = {28'h0000000, cm};
            mist_pkg::OFS_HALF_CYCLES: d = {16'h0000, hc};
            default: d = 32'h00000000;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // supply monitor synchroniser and reset event

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sup_meta_r <= 1'b0;
            sup_sync_r <= 1'b0;
            sup_prev_r <= 1'b0;
        end
        else if (CE)
        begin
            sup_meta_r <= SUPPLY_LOW;
            sup_sync_r <= sup_meta_r;
            sup_prev_r <= sup_sync_r;
        end
    end

    // supply drop or software request restarts every software register and status flag
    assign soft_req = (sup_sync_r && !sup_prev_r) // see [RQ5]
        || (wr_pend_r && addr_r == mist_pkg::OFS_CONTROL
        && HWDATA[mist_pkg::CTRL_SOFT_RESET]); // see [RQ7]

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            soft_rst_r <= 1'b0;
        else if (CE)
            soft_rst_r <= soft_req;
    end

    assign SW_RESET_PULSE = soft_rst_r;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states

    assign acc = HSEL && HTRANS[1] && HREADY && CE;
    assign HREADYOUT = CE;
    assign HRESP = 1'b0;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end
        else if (CE)
        begin
            wr_pend_r <= acc && HWRITE;
            if (acc)
                addr_r <= HADDR[7:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            hrdata_r <= 32'h00000000;
        else if (acc && !HWRITE)
            hrdata_r <= rd_mux(HADDR[7:0], ev.status, mask_r, volt_peak_threshold,
                curr_peak_threshold, measure_mode_reg, computation_mode_reg,
                half_cycle_count); // see [RQ16]
    end

    assign HRDATA = hrdata_r;

    // flags clear at the edge that captures the clear-view data
    assign ev.clr_rd = acc && !HWRITE
        && HADDR[7:0] == mist_pkg::OFS_CLEAR_VIEW; // see [RQ16]

    ////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            mask_r <= mist_pkg::MASK_RST;
            volt_peak_threshold <= mist_pkg::VPEAK_RST;
            curr_peak_threshold <= mist_pkg::IPEAK_RST;
            measure_mode_reg <= mist_pkg::MEASURE_RST;
            computation_mode_reg <= mist_pkg::COMP_RST;
            half_cycle_count <= mist_pkg::LCYC_RST;
        end
        else if (CE)
        begin
            if (soft_rst_r)
            begin
                mask_r <= mist_pkg::MASK_RST; // see [RQ7]
                volt_peak_threshold <= mist_pkg::VPEAK_RST;
                curr_peak_threshold <= mist_pkg::IPEAK_RST;
                measure_mode_reg <= mist_pkg::MEASURE_RST;
                computation_mode_reg <= mist_pkg::COMP_RST;
                half_cycle_count <= mist_pkg::LCYC_RST;
            end
            else if (wr_pend_r)
            begin
                case (addr_r)
                    mist_pkg::OFS_MASK:
                        mask_r <= HWDATA[mist_pkg::STATUS_W-1:0] & mist_pkg::MASK_WR;
                    mist_pkg::OFS_VPEAK_THR:
                        volt_peak_threshold <= HWDATA[mist_pkg::MAG_W-1:0];
                    mist_pkg::OFS_IPEAK_THR:
                        curr_peak_threshold <= HWDATA[mist_pkg::MAG_W-1:0];
                    mist_pkg::OFS_MEASURE_MODE:
                        measure_mode_reg <= HWDATA[3:0];
                    mist_pkg::OFS_COMP_MODE:
                        computation_mode_reg <= HWDATA[3:0];
                    mist_pkg::OFS_HALF_CYCLES:
                        half_cycle_count <= HWDATA[mist_pkg::LCYC_W-1:0];
                    default:
                        mask_r <= mask_r;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // peak detection on the selected phases

    assign volt_peak_hit = MAG_VALID && pick_mag(VOLT_MAG,
        measure_mode_reg[mist_pkg::MM_VSEL_LO +: 2]) > volt_peak_threshold; // see [RQ8]
    assign curr_peak_hit = MAG_VALID && pick_mag(CURR_MAG,
        measure_mode_reg[mist_pkg::MM_ISEL_LO +: 2]) > curr_peak_threshold; // see [RQ9]

    ////////////////////////////////////////////////////////////////////////
    // phase order: after an A crossing, B before C is an error

    always_comb
    begin
        seq_nxt = seq_r;
        seq_err_hit = 1'b0;
        case (seq_r)
            SEQ_IDLE:
                if (ZC_RISE_EVT[0])
                    seq_nxt = SEQ_AFTER_A;
            SEQ_AFTER_A:
                if (ZC_RISE_EVT[1])
                begin
                    seq_err_hit = 1'b1; // see [RQ13]
                    seq_nxt = ZC_RISE_EVT[0] ? SEQ_AFTER_A : SEQ_IDLE;
                end
                else if (ZC_RISE_EVT[2])
                    seq_nxt = ZC_RISE_EVT[0] ? SEQ_AFTER_A : SEQ_IDLE;
            default:
                seq_nxt = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            seq_r <= SEQ_IDLE;
        else if (CE)
            seq_r <= soft_rst_r ? SEQ_IDLE : seq_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // event vector into the flag bank

    always_comb
    begin
        set_vec = '0;
        set_vec[mist_pkg::BIT_SAG_C] = SAG_C_EVT; // see [RQ1]
        set_vec[mist_pkg::BIT_ZC_TIMEOUT_A +: 3] = ZC_TIMEOUT_EVT; // see [RQ2]
        set_vec[mist_pkg::BIT_ZC_RISE_A +: 3] = ZC_RISE_EVT; // see [RQ3]
        set_vec[mist_pkg::BIT_LINE_CYCLE] = ev.line_done; // see [RQ4]
        set_vec[mist_pkg::BIT_VPEAK] = volt_peak_hit;
        set_vec[mist_pkg::BIT_IPEAK] = curr_peak_hit;
        set_vec[mist_pkg::BIT_WAVE] = WAVE_SAMPLE_EVT; // see [RQ10]
        set_vec[mist_pkg::BIT_ACT_FLIP] = ev.act_flip;
        set_vec[mist_pkg::BIT_REACT_FLIP] = ev.react_flip;
        set_vec[mist_pkg::BIT_SEQ_ERR] = seq_err_hit;
    end

    assign ev.set_vec = set_vec;
    assign ev.ce = CE;
    assign ev.soft_rst = soft_rst_r;
    assign ev.phase_sel = computation_mode_reg[2:0];
    assign ev.lcyc_en = computation_mode_reg[mist_pkg::CM_LCYC_EN];
    assign ev.half_cycles = half_cycle_count;

    mist_flag_bank u_bank (
        .clk(CLK),
        .reset_n(RESET_N),
        .ev(ev.bank)
    );

    mist_power_events u_pwr (
        .clk(CLK),
        .reset_n(RESET_N),
        .ev(ev.pwr),
        .act_sign(ACT_SIGN),
        .react_sign(REACT_SIGN),
        .pwr_valid(PWR_VALID),
        .half_cycle(HALF_CYCLE_EVT)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt pin, registered

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            irq_n_r <= 1'b1;
        else if (CE)
            irq_n_r <= ~|(ev.status & mask_r); // see [RQ15] see [RQ17]
    end

    assign IRQ_N = irq_n_r;
endmodule

// ### logic/mist_pkg.sv
// constants for the meter interrupt status flag block
// Summary of operation
// [RQ1] bit 5 flags phase C sag
// [RQ2] bits 6-8 flag missing zero crossings A/B/C
// [RQ3] bits 9-11 flag rising zero crossings A/B/C
// [RQ4] bit 12 flags line-cycle accumulation done
// [RQ5] bit 13 flags supply below 4 V
// [RQ6] bit 13 is one after reset, one cycle
// [RQ7] reset event restores every register default
// [RQ8] bit 14 flags selected voltage above threshold
// [RQ9] bit 15 flags selected current above threshold
// [RQ10] bit 16 flags new waveform sample
// [RQ11] bit 17 flags active sign change, selected phases
// [RQ12] bit 18 flags reactive sign change, selected phases
// [RQ13] bit 19 flags A followed by B crossing
// [RQ14] flags stay high after their event
// [RQ15] interrupt low while any enabled flag set
// [RQ16] host reads status; clear view read clears
// [RQ17] interrupt released when no enabled flag set
// [RQ18] event during clearing read stays set
package mist_pkg;
    localparam int STATUS_W = 20;
    localparam int FLAG_LO = 5;
    localparam int FLAG_HI = 19;
    localparam int MAG_W = 12;
    localparam int LCYC_W = 16;
    localparam int NPH = 3;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CLEAR_VIEW = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_VPEAK_THR = 8'h0c;
    localparam logic [7:0] OFS_IPEAK_THR = 8'h10;
    localparam logic [7:0] OFS_MEASURE_MODE = 8'h14;
    localparam logic [7:0] OFS_COMP_MODE = 8'h18;
    localparam logic [7:0] OFS_HALF_CYCLES = 8'h1c;
    localparam logic [7:0] OFS_CONTROL = 8'h20;
    // status bit positions
    localparam int BIT_SAG_C = 5;
    localparam int BIT_ZC_TIMEOUT_A = 6;
    localparam int BIT_ZC_RISE_A = 9;
    localparam int BIT_LINE_CYCLE = 12;
    localparam int BIT_RESET = 13;
    localparam int BIT_VPEAK = 14;
    localparam int BIT_IPEAK = 15;
    localparam int BIT_WAVE = 16;
    localparam int BIT_ACT_FLIP = 17;
    localparam int BIT_REACT_FLIP = 18;
    localparam int BIT_SEQ_ERR = 19;
    // field positions
    localparam int MM_VSEL_LO = 0;
    localparam int MM_ISEL_LO = 2;
    localparam int CM_LCYC_EN = 3;
    localparam int CTRL_SOFT_RESET = 0;
    // reset values and writable masks
    localparam logic [STATUS_W-1:0] STATUS_RST = 20'h02000;
    localparam logic [STATUS_W-1:0] MASK_RST = 20'h00000;
    localparam logic [STATUS_W-1:0] MASK_WR = 20'hfdfe0;
    localparam logic [MAG_W-1:0] VPEAK_RST = 12'hfff;
    localparam logic [MAG_W-1:0] IPEAK_RST = 12'hfff;
    localparam logic [3:0] MEASURE_RST = 4'h0;
    localparam logic [3:0] COMP_RST = 4'h7;
    localparam logic [LCYC_W-1:0] LCYC_RST = 16'h00ff;
endpackage

// ### logic/mist_evt_if.sv
// carrier between the top and its flag bank and power event modules
`timescale 1ns/1ps
interface mist_evt_if;
    logic ce;
    logic soft_rst;
    logic clr_rd;
    logic [mist_pkg::STATUS_W-1:0] set_vec;
    logic [mist_pkg::STATUS_W-1:0] status;
    logic [mist_pkg::NPH-1:0] phase_sel;
    logic lcyc_en;
    logic [mist_pkg::LCYC_W-1:0] half_cycles;
    logic line_done;
    logic act_flip;
    logic react_flip;
    modport ctl (output ce, soft_rst, clr_rd, set_vec, phase_sel, lcyc_en, half_cycles,
        input status, line_done, act_flip, react_flip);
    modport bank (input ce, soft_rst, clr_rd, set_vec, output status);
    modport pwr (input ce, soft_rst, phase_sel, lcyc_en, half_cycles,
        output line_done, act_flip, react_flip);
endinterface

// ### logic/mist_flag_bank.sv
// sticky interrupt status flags with clear-on-read
`timescale 1ns/1ps
module mist_flag_bank (
    input wire logic clk,
    input wire logic reset_n,
    mist_evt_if.bank ev
);
    logic [mist_pkg::STATUS_W-1:0] status_r;

    assign ev.status = status_r;

    // reset flag: one after any reset, gone one cycle later
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            status_r[mist_pkg::BIT_RESET] <= 1'b1; // see [RQ6]
        else if (ev.ce)
            status_r[mist_pkg::BIT_RESET] <= ev.soft_rst; // see [RQ5] see [RQ6]
    end

    for (genvar i = 0; i < mist_pkg::STATUS_W; i++)
    begin : g_flag
        if (i >= mist_pkg::FLAG_LO && i != mist_pkg::BIT_RESET)
        begin : g_sticky
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    status_r[i] <= mist_pkg::STATUS_RST[i];
                else if (ev.ce)
                begin
                    if (ev.soft_rst)
                        status_r[i] <= mist_pkg::STATUS_RST[i]; // see [RQ7]
                    else if (ev.set_vec[i])
                        status_r[i] <= 1'b1; // see [RQ14] see [RQ18]
                    else if (ev.clr_rd)
                        status_r[i] <= mist_pkg::STATUS_RST[i]; // see [RQ16]
                end
            end
        end
        else if (i != mist_pkg::BIT_RESET)
        begin : g_unused
            assign status_r[i] = 1'b0;
        end
    end
endmodule

// ### logic/mist_power_events.sv
// power sign change and line-cycle completion events
`timescale 1ns/1ps
module mist_power_events (
    input wire logic clk,
    input wire logic reset_n,
    mist_evt_if.pwr ev,
    input wire logic [mist_pkg::NPH-1:0] act_sign,
    input wire logic [mist_pkg::NPH-1:0] react_sign,
    input wire logic pwr_valid,
    input wire logic half_cycle
);
    logic [mist_pkg::NPH-1:0] act_prev_r;
    logic [mist_pkg::NPH-1:0] react_prev_r;
    logic primed_r;
    logic [mist_pkg::LCYC_W-1:0] hc_cnt_r;
    logic hc_last;

    // first valid sample only loads the previous sign
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            act_prev_r <= '0;
            react_prev_r <= '0;
            primed_r <= 1'b0;
        end
        else if (ev.ce)
        begin
            if (ev.soft_rst)
            begin
                act_prev_r <= '0;
                react_prev_r <= '0;
                primed_r <= 1'b0;
            end
            else if (pwr_valid)
            begin
                act_prev_r <= act_sign;
                react_prev_r <= react_sign;
                primed_r <= 1'b1;
            end
        end
    end

    assign ev.act_flip = pwr_valid && primed_r
        && |((act_sign ^ act_prev_r) & ev.phase_sel); // see [RQ11]
    assign ev.react_flip = pwr_valid && primed_r
        && |((react_sign ^ react_prev_r) & ev.phase_sel); // see [RQ12]

    // counts half line cycles up to the programmed number
    assign hc_last = hc_cnt_r + 16'h0001 >= ev.half_cycles;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hc_cnt_r <= '0;
        else if (ev.ce)
        begin
            if (ev.soft_rst || !ev.lcyc_en)
                hc_cnt_r <= '0;
            else if (half_cycle)
                hc_cnt_r <= hc_last ? '0 : hc_cnt_r + 16'h0001;
        end
    end

    assign ev.line_done = ev.lcyc_en && half_cycle && hc_last; // see [RQ4]
endmodule

// ### dv/mist_top_props.sv
// assertions on the block ports
`timescale 1ns/1ps
module mist_top_props (
    input CLK,
    input RESET_N,
    input CE,
    input HSEL,
    input [31:0] HADDR,
    input [1:0] HTRANS,
    input HWRITE,
    input [31:0] HWDATA,
    input HREADY,
    input HREADYOUT,
    input [31:0] HRDATA,
    input HRESP,
    input SAG_C_EVT,
    input [2:0] ZC_TIMEOUT_EVT,
    input [2:0] ZC_RISE_EVT,
    input WAVE_SAMPLE_EVT,
    input SW_RESET_PULSE,
    input IRQ_N
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    localparam logic [19:0] DIRECT = 20'h10fe0;
    logic acc, rd_acc, clr_acc, wr_mask_r;
    logic [19:0] mask_r, shadow_r, ev_set;
    assign acc = HSEL && HTRANS[1] && HREADY && CE;
    assign rd_acc = acc && !HWRITE;
    assign clr_acc = rd_acc && HADDR[7:0] == mist_pkg::OFS_CLEAR_VIEW;
    assign ev_set = {3'h0, WAVE_SAMPLE_EVT, 4'h0, ZC_RISE_EVT, ZC_TIMEOUT_EVT, SAG_C_EVT, 5'h0};
    ////////////////////////////////////////
    // flags fed straight from event pins
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            shadow_r <= '0;
        else if (SW_RESET_PULSE)
            shadow_r <= '0;
        else
            shadow_r <= (clr_acc ? 20'h0 : shadow_r) | ev_set;
    end
    // mask after its write data
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_mask_r <= 1'b0;
            mask_r <= '0;
        end
        else
        begin
            wr_mask_r <= acc && HWRITE && HADDR[7:0] == mist_pkg::OFS_MASK;
            if (SW_RESET_PULSE)
                mask_r <= '0;
            else if (wr_mask_r)
                mask_r <= HWDATA[19:0] & mist_pkg::MASK_WR;
        end
    end
    ////////////////////////////////////////
    chk_resp_okay: assert property (HRESP == 1'b0)
        else $error("bad response");
    chk_ready_ce: assert property (HREADYOUT == CE)
        else $error("ready not ce");
    chk_rdata_upper: assert property (HRDATA[31:20] == 12'h000)
        else $error("upper bits set");
    chk_unmapped_zero: assert property (rd_acc && HADDR[7:0] >= 8'h24 |=> HRDATA == 32'h0)
        else $error("unmapped not zero");
    chk_rdata_holds: assert property (!$past(rd_acc) && !$past(SW_RESET_PULSE) |-> $stable(HRDATA))
        else $error("read data moved");
    chk_flags_sticky: assert property (rd_acc && (HADDR[7:0] == mist_pkg::OFS_STATUS || clr_acc)
        |=> (HRDATA[19:0] & DIRECT) == ($past(shadow_r) & DIRECT))
        else $error("flags differ");
    chk_irq_on_flag: assert property (|(shadow_r & mask_r) && !SW_RESET_PULSE |=> !IRQ_N)
        else $error("irq not low");
    chk_swrst_single: assert property (SW_RESET_PULSE |=> !SW_RESET_PULSE)
        else $error("pulse too long");
    chk_irq_after_swrst: assert property (SW_RESET_PULSE |-> ##2 IRQ_N)
        else $error("irq not released");
endmodule

// ### dv/mist_host.sv
// host bus master model
`timescale 1ns/1ps
module mist_host (
    input clk,
    input hready,
    input [31:0] hrdata,
    input irq_n,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial
    begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : ~hwdata;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // read source, then clear view
    task automatic service(output logic [31:0] st);
        logic [31:0] q;
        while (irq_n !== 1'b0)
            @(posedge clk);
        xfer(1'b0, mist_pkg::OFS_STATUS, 32'h0, st);
        xfer(1'b0, mist_pkg::OFS_CLEAR_VIEW, 32'h0, q);
    endtask
endmodule

// ### dv/mist_top_tb.sv
// self-checking bench for the status block
`timescale 1ns/1ps
module mist_top_tb;
    logic clk, reset_n, ce, hsel, hwrite, hready, hresp, supply_low, sag, half, wave;
    logic mag_valid, pwr_valid, sw_pulse, irq_n;
    logic [31:0] haddr, hwdata, hrdata, q, e32;
    logic [1:0] htrans;
    logic [2:0] hsize, zc_to, zc_rise, act, react;
    logic [35:0] vmag, imag;
    int error_cnt = 0, comparisons = 0, cycles = 0, n;
    logic [7:0] evs [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h20, 8'h80};
    logic [7:0] ra [9] = '{mist_pkg::OFS_STATUS, mist_pkg::OFS_CLEAR_VIEW, mist_pkg::OFS_MASK,
        mist_pkg::OFS_VPEAK_THR, mist_pkg::OFS_IPEAK_THR, mist_pkg::OFS_MEASURE_MODE,
        mist_pkg::OFS_COMP_MODE, mist_pkg::OFS_HALF_CYCLES, 8'h24};
    logic [31:0] rv [9] = '{32'h0, 32'h0, {12'h0, mist_pkg::MASK_RST},
        {20'h0, mist_pkg::VPEAK_RST}, {20'h0, mist_pkg::IPEAK_RST},
        {28'h0, mist_pkg::MEASURE_RST}, {28'h0, mist_pkg::COMP_RST},
        {16'h0, mist_pkg::LCYC_RST}, 32'h0};
    mist_top dut_u (.CLK(clk), .RESET_N(reset_n), .CE(ce), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .SUPPLY_LOW(supply_low),
        .SAG_C_EVT(sag), .ZC_TIMEOUT_EVT(zc_to), .ZC_RISE_EVT(zc_rise), .HALF_CYCLE_EVT(half),
        .WAVE_SAMPLE_EVT(wave), .VOLT_MAG(vmag), .CURR_MAG(imag), .MAG_VALID(mag_valid),
        .ACT_SIGN(act), .REACT_SIGN(react), .PWR_VALID(pwr_valid), .SW_RESET_PULSE(sw_pulse),
        .IRQ_N(irq_n));
    mist_host host_u (.clk(clk), .hready(hready), .hrdata(hrdata), .irq_n(irq_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, a, 32'h0, q);
        check($sformatf("reg %h", a), q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge clk);
        {wave, zc_rise, zc_to, sag} <= e;
        @(posedge clk);
        {wave, zc_rise, zc_to, sag} <= 8'h00;
    endtask
    task automatic mag(input logic [35:0] v, input logic [35:0] i);
        @(posedge clk);
        {vmag, imag, mag_valid} <= {v, i, 1'b1};
        @(posedge clk);
        mag_valid <= 1'b0;
    endtask
    task automatic psig(input logic [2:0] a, input logic [2:0] r);
        @(posedge clk);
        {act, react, pwr_valid} <= {a, r, 1'b1};
        @(posedge clk);
        pwr_valid <= 1'b0;
    endtask
    task automatic hpulse(input int k);
        repeat (k)
        begin
            @(posedge clk);
            half <= 1'b1;
            @(posedge clk);
            half <= 1'b0;
        end
    endtask
    task automatic waitrst();
        n = 0;
        while (sw_pulse !== 1'b1 && n < 8)
        begin
            @(posedge clk);
            n++;
        end
        check("reset pulse", {31'h0, sw_pulse}, 32'h1);
    endtask
    ////////////////////////////////////////
    initial
    begin
        {reset_n, supply_low, sag, zc_to, zc_rise, half, wave, mag_valid, pwr_valid} = '0;
        {act, react, vmag, imag} = '0;
        ce = 1'b1;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd(ra[i], rv[i]);
        wr(8'h24, 32'hffffffff);
        rd(8'h24, 32'h0);
        wr(mist_pkg::OFS_STATUS, 32'hffffffff);
        rd(mist_pkg::OFS_STATUS, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            pulse(evs[i]);
            e32 = {15'h0, evs[i][7], 4'h0, evs[i][6:0], 5'h0};
            rd(mist_pkg::OFS_STATUS, e32);
            rd(mist_pkg::OFS_STATUS, e32);
            rd(mist_pkg::OFS_CLEAR_VIEW, e32);
            rd(mist_pkg::OFS_STATUS, 32'h0);
        end
        pulse(8'h10);
        pulse(8'h20);
        rd(mist_pkg::OFS_CLEAR_VIEW, 32'h80600);
        wr(mist_pkg::OFS_MASK, 32'hffffffff);
        rd(mist_pkg::OFS_MASK, {12'h0, mist_pkg::MASK_WR});
        pulse(8'h01);
        repeat (2) @(posedge clk);
        check("irq low", {31'h0, irq_n}, 32'h0);
        host_u.service(q);
        check("status", q, 32'h20);
        repeat (2) @(posedge clk);
        check("irq released", {31'h0, irq_n}, 32'h1);
        wr(mist_pkg::OFS_MASK, 32'h0);
        pulse(8'h01);
        repeat (3) @(posedge clk);
        check("irq masked", {31'h0, irq_n}, 32'h1);
        fork
            host_u.xfer(1'b0, mist_pkg::OFS_CLEAR_VIEW, 32'h0, e32);
            pulse(8'h01);
        join
        check("clear view", e32, 32'h20);
        rd(mist_pkg::OFS_CLEAR_VIEW, 32'h20);
        wr(mist_pkg::OFS_VPEAK_THR, 32'h100);
        wr(mist_pkg::OFS_IPEAK_THR, 32'h200);
        wr(mist_pkg::OFS_MEASURE_MODE, 32'h9);
        mag({24'h000100, 12'hfff}, {12'h200, 24'hffffff});
        rd(mist_pkg::OFS_STATUS, 32'h0);
        mag({24'h000101, 12'h000}, {12'h201, 24'h000000});
        rd(mist_pkg::OFS_CLEAR_VIEW, 32'hc000);
        wr(mist_pkg::OFS_COMP_MODE, 32'h2);
        psig(3'b000, 3'b000);
        psig(3'b001, 3'b001);
        rd(mist_pkg::OFS_STATUS, 32'h0);
        psig(3'b011, 3'b001);
        rd(mist_pkg::OFS_CLEAR_VIEW, 32'h20000);
        psig(3'b011, 3'b011);
        rd(mist_pkg::OFS_CLEAR_VIEW, 32'h40000);
        wr(mist_pkg::OFS_HALF_CYCLES, 32'h3);
        wr(mist_pkg::OFS_COMP_MODE, 32'hf);
        hpulse(2);
        rd(mist_pkg::OFS_STATUS, 32'h0);
        hpulse(1);
        rd(mist_pkg::OFS_STATUS, 32'h1000);
        wr(mist_pkg::OFS_CONTROL, 32'h1);
        waitrst();
        repeat (3) @(posedge clk);
        for (int i = 0; i < 9; i++)
            rd(ra[i], rv[i]);
        wr(mist_pkg::OFS_VPEAK_THR, 32'h123);
        supply_low <= 1'b1;
        waitrst();
        supply_low <= 1'b0;
        repeat (3) @(posedge clk);
        rd(mist_pkg::OFS_VPEAK_THR, 32'hfff);
        print_verdict();
    end
endmodule
bind mist_top mist_top_props chk_u (.*);
